// ---- logic/cscr_edge.sv ----
// One-shot pulse generator: one cycle high for each zero-to-one step of a level.
// Assumes levels from logic on the same clock.
module cscr_edge
#(
  parameter int N = 5
)
(
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Levels and pulses
  input  wire logic [N-1:0] lvl_i,
  output logic      [N-1:0] pulse_q
);

  logic [N-1:0] prev_q;

  // A bit held high, or rewritten high, gives no second pulse.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prev_q  <= '0;
      pulse_q <= '0;
    end
    else
    begin
      prev_q  <= lvl_i;
      pulse_q <= lvl_i & ~prev_q;
    end
  end

endmodule

// ---- logic/cscr_map.svh ----
// Register offsets, reset values and field positions of the configuration bank.
// Assumes inclusion by the top module of the bank and by its bench.
`ifndef CSCR_MAP_SVH
`define CSCR_MAP_SVH

// ----------------------------------------------------------------------------
// Register count and index of each register inside the bank
// ----------------------------------------------------------------------------
`define CSCR_NREG        15
`define CSCR_IDX_PLL3    0
`define CSCR_IDX_FRAC_L  1
`define CSCR_IDX_FRAC_M  2
`define CSCR_IDX_FRAC_H  3
`define CSCR_IDX_BUS     4
`define CSCR_IDX_OSC     5
`define CSCR_IDX_GAIN    6
`define CSCR_IDX_DRV     7
`define CSCR_IDX_ADDR    8
`define CSCR_IDX_GM      9
`define CSCR_IDX_TRIM    10
`define CSCR_IDX_OVT     11
`define CSCR_IDX_ACT1    12
`define CSCR_IDX_NVPC    13
`define CSCR_IDX_ACT2    14
`define CSCR_NCFG        12
`define CSCR_COPY_MASK   15'h2fff

// ----------------------------------------------------------------------------
// Serial register offsets
// ----------------------------------------------------------------------------
`define CSCR_OFF_PLL3    8'h42
`define CSCR_OFF_FRAC_L  8'h43
`define CSCR_OFF_FRAC_M  8'h44
`define CSCR_OFF_FRAC_H  8'h45
`define CSCR_OFF_BUS     8'h50
`define CSCR_OFF_OSC     8'h51
`define CSCR_OFF_GAIN    8'h52
`define CSCR_OFF_DRV     8'h53
`define CSCR_OFF_ADDR    8'h54
`define CSCR_OFF_GM      8'h55
`define CSCR_OFF_TRIM    8'h56
`define CSCR_OFF_OVT     8'h57
`define CSCR_OFF_ACT1    8'h60
`define CSCR_OFF_NVPC    8'h61
`define CSCR_OFF_ACT2    8'h62

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define CSCR_RST_PLL3    8'h0a
`define CSCR_RST_FRAC_L  8'h00
`define CSCR_RST_FRAC_M  8'h00
`define CSCR_RST_FRAC_H  8'hc0
`define CSCR_RST_BUS     8'h15
`define CSCR_RST_OSC     8'hc0
`define CSCR_RST_GAIN    8'h2a
`define CSCR_RST_DRV     8'h82
`define CSCR_RST_ADDR    8'h00
`define CSCR_RST_GM      8'h94
`define CSCR_RST_TRIM    8'h82
`define CSCR_RST_OVT     8'h58
`define CSCR_RST_ACT1    8'h00
`define CSCR_RST_NVPC    8'h00
`define CSCR_RST_ACT2    8'h00
`define CSCR_DEF_DEV     7'h50

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define CSCR_B_PLL_MODE  0
`define CSCR_B_BUS_HS    4
`define CSCR_B_CMOS_EN   3
`define CSCR_B_DBL_DIS   7
`define CSCR_B_FIXED     2
`define CSCR_B_SLOPE     7
`define CSCR_B_OE_POL    7
`define CSCR_B_ADDR_OVR  7
`define CSCR_B_BYPASS    3
`define CSCR_B_FUND      7
`define CSCR_B_COPY      7
`define CSCR_B_PUSH      5
`define CSCR_B_CAL       0
`define CSCR_B_SMALL     1
`define CSCR_B_LARGE     0

`endif

// ---- logic/cscr_pkg.sv ----
// Types shared by the configuration bank modules.
// Assumes nothing of its surroundings.
package cscr_pkg;

  typedef logic [7:0] cscr_byte_t;

  // Serial slave progress through one bus transaction.
  typedef enum logic [3:0]
  {
    CSCR_IDLE,
    CSCR_DEV,
    CSCR_DEV_ACK,
    CSCR_REG,
    CSCR_REG_ACK,
    CSCR_WDATA,
    CSCR_WACK,
    CSCR_RDATA,
    CSCR_RACK,
    CSCR_SKIP
  } cscr_state_t;

endpackage

// ---- logic/cscr_sync.sv ----
// Two-stage synchroniser for levels entering the reference clock domain.
// Assumes an already synchronised active-low reset.
module cscr_sync
#(
  parameter int W = 2
)
(
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Levels
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] meta_q;

  // The first stage feeds the second stage only.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= '0;
      sync_o <= '0;
    end
    else
    begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end

endmodule

// ---- logic/cscr_top.sv ----
// Volatile configuration bank of a crystal PLL clock synthesiser, with its two-wire slave.
// Assumes open-drain bus pins resolved outside and a nonvolatile image on ref_clk.
//
// What this block does
// - Profile 3 control bit 0: zero fractional, one integer loop; resets zero.
// - Profile 3 control bits 5:4 hold feedback integer bits 9:8, default 00.
// - Profile 3 charge pump field is 3 bits, resets to 101, writable.
// - Profile 3 fraction is three bytes, low first; resets 00, 00, C0.
// - Bus speed bit, default one: zero up to 400kHz, one up to 800kHz.
// - Oscillator byte bit 7 high disables the reference doubler; default one.
// - Supply code, default 10: 00 is 1.8V, 01 2.5V, 10 3.3V.
// - Oscillator byte bit 2: zero voltage-controlled mode, one fixed mode.
// - Modulation bandwidth, default 00: 00 10kHz, 01 20kHz, 10 5kHz.
// - Gain byte: slope bit default zero, exponent 010, scale 1010.
// - Output enable polarity bit defaults one: one active high, zero low.
// - Output logic type 3 bits, default 000, selects the driver standard.
// - Override bit zero answers at the default address 50h (CSCR_DEF_DEV), one at the byte's low 7 bits.
// - Trim byte bit 3 bypasses the oscillator; bits 2:0 trim, default 010.
// - Overtone byte bit 7 one selects fundamental; bits 6:4 resistor, default 101.
// - Transconductance byte defaults 10 and 01 0100; slice field defaults 1000.
// - Rising action bit 7 copies the nonvolatile image; host clears it after.
// - Rising action bit 5 applies the register contents; host clears it after.
// - Rising action bit 0 starts loop calibration; host clears it after.
// - Byte after action byte: 2-bit programming control, upper bits reserved, zero; the register stores and reads back all 8 bits.
// - Rising second action bit 1 applies a small change; host clears it.
// - Rising second action bit 0 applies a large change; host clears it.
`include "cscr_map.svh"
module cscr_top
  (
  // Clock and reset
  input  wire logic                       ref_clk,
  input  wire logic                       rst_b,
  // Two-wire serial pins
  input  wire logic                       scl_i,
  input  wire logic                       sda_i,
  output logic                            sda_o,
  output logic                            sda_oe,
  // Nonvolatile image, one byte per register index
  input  wire logic [`CSCR_NREG*8-1:0]    nv_image,
  // Profile 3 applied settings
  output logic                            pll_integer_mode,
  output logic [1:0]                      fb_int_high,
  output logic                            cp_offset_en,
  output logic [2:0]                      charge_pump,
  output logic [23:0]                     fb_fraction,
  // Miscellaneous applied settings
  output logic                            hs_bus_en,
  output logic                            cmos_out_en,
  output logic                            doubler_dis,
  output logic [1:0]                      supply_code,
  output logic                            fixed_osc_mode,
  output logic [1:0]                      mod_bandwidth,
  output logic                            gain_slope_neg,
  output logic [2:0]                      gain_exponent,
  output logic [3:0]                      gain_scale,
  output logic                            oe_active_high,
  output logic [2:0]                      logic_type,
  output cscr_pkg::cscr_byte_t            amplifier_transconductance_code,
  output logic [3:0]                      amp_slice,
  output logic                            xo_bypass,
  output logic [2:0]                      load_cap_trim,
  output logic                            fundamental_mode,
  output logic [2:0]                      filter_res,
  // Actions
  output logic [1:0]                      nv_prog_ctrl,
  output logic                            cal_start
  );

  import cscr_pkg::*;

  // --------------------------------------------------------------------------
  // Register map tables
  // --------------------------------------------------------------------------
  localparam cscr_byte_t OFFS [`CSCR_NREG] = '{
    `CSCR_OFF_PLL3, `CSCR_OFF_FRAC_L, `CSCR_OFF_FRAC_M, `CSCR_OFF_FRAC_H,
    `CSCR_OFF_BUS, `CSCR_OFF_OSC, `CSCR_OFF_GAIN, `CSCR_OFF_DRV, `CSCR_OFF_ADDR,
    `CSCR_OFF_GM, `CSCR_OFF_TRIM, `CSCR_OFF_OVT, `CSCR_OFF_ACT1, `CSCR_OFF_NVPC,
    `CSCR_OFF_ACT2};
  localparam cscr_byte_t RSTV [`CSCR_NREG] = '{
    `CSCR_RST_PLL3, `CSCR_RST_FRAC_L, `CSCR_RST_FRAC_M, `CSCR_RST_FRAC_H,
    `CSCR_RST_BUS, `CSCR_RST_OSC, `CSCR_RST_GAIN, `CSCR_RST_DRV, `CSCR_RST_ADDR,
    `CSCR_RST_GM, `CSCR_RST_TRIM, `CSCR_RST_OVT, `CSCR_RST_ACT1, `CSCR_RST_NVPC,
    `CSCR_RST_ACT2};
  localparam logic [`CSCR_NREG-1:0] COPY_MASK = `CSCR_COPY_MASK;

  // --------------------------------------------------------------------------
  // Reset release and pin synchronisation
  // --------------------------------------------------------------------------
  logic        rst_meta_q;
  logic        rst_sync_b;
  logic        scl_s;
  logic        sda_s;
  logic        scl_prev_q;
  logic        sda_prev_q;

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_meta_q <= 1'b0;
      rst_sync_b <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_sync_b <= rst_meta_q;
    end
  end

  cscr_sync #(.W(2)) u_pin_sync
  (
    .clk     (ref_clk),
    .rst_n   (rst_sync_b),
    .async_i ({scl_i, sda_i}),
    .sync_o  ({scl_s, sda_s})
  );

  always_ff @(posedge ref_clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end
    else
    begin
      scl_prev_q <= scl_s;
      sda_prev_q <= sda_s;
    end
  end

  // Both pins share the same latency, so a data change inside a clock-low
  // phase is never mistaken for a start or stop.
  wire scl_rise = scl_s & ~scl_prev_q;
  wire scl_fall = ~scl_s & scl_prev_q;
  wire start_c  = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
  wire stop_c   = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

  // --------------------------------------------------------------------------
  // Register storage
  // --------------------------------------------------------------------------
  cscr_byte_t               regs_q [`CSCR_NREG];
  cscr_byte_t               act_q  [`CSCR_NCFG];
  cscr_byte_t               rd_acc [`CSCR_NREG+1];
  logic [`CSCR_NREG-1:0]    hit;
  logic                     wr_en;
  logic                     push_any;
  logic [4:0]               trig_pulse;
  cscr_byte_t               ptr_q;
  cscr_byte_t               sh_q;
  cscr_byte_t               rd_data;

  assign rd_acc[0] = '0;
  assign rd_data   = rd_acc[`CSCR_NREG];

  // Host write wins over the image copy; the copy never touches the action bytes,
  // so a copy cannot re-arm or clear its own trigger.
  for (genvar i = 0; i < `CSCR_NREG; i++)
  begin : g_reg
    assign hit[i]      = (ptr_q == OFFS[i]);
    assign rd_acc[i+1] = rd_acc[i] | (hit[i] ? regs_q[i] : '0);

    always_ff @(posedge ref_clk or negedge rst_sync_b)
    begin
      if (!rst_sync_b)
        regs_q[i] <= RSTV[i];
      else if (wr_en && hit[i])
        regs_q[i] <= sh_q;
      else if (trig_pulse[0] && COPY_MASK[i])
        regs_q[i] <= nv_image[i*8 +: 8];
    end
  end

  // Applied settings follow the register contents only on a push, a large change or a small change.
  for (genvar i = 0; i < `CSCR_NCFG; i++)
  begin : g_act
    always_ff @(posedge ref_clk or negedge rst_sync_b)
    begin
      if (!rst_sync_b)
        act_q[i] <= RSTV[i];
      else if (push_any)
        act_q[i] <= regs_q[i];
    end
  end

  // --------------------------------------------------------------------------
  // Action triggers
  // --------------------------------------------------------------------------
  cscr_edge #(.N(5)) u_trig
  (
    .clk     (ref_clk),
    .rst_n   (rst_sync_b),
    .lvl_i   ({regs_q[`CSCR_IDX_ACT2][`CSCR_B_SMALL],
               regs_q[`CSCR_IDX_ACT2][`CSCR_B_LARGE],
               regs_q[`CSCR_IDX_ACT1][`CSCR_B_CAL],
               regs_q[`CSCR_IDX_ACT1][`CSCR_B_PUSH],
               regs_q[`CSCR_IDX_ACT1][`CSCR_B_COPY]}),
    .pulse_q (trig_pulse)
  );

  // Pulses: 0 copy, 1 push, 2 calibrate, 3 large change, 4 small change.
  assign push_any  = trig_pulse[1] | trig_pulse[3] | trig_pulse[4];
  assign cal_start = trig_pulse[2];

  // --------------------------------------------------------------------------
  // Serial slave
  // --------------------------------------------------------------------------
  cscr_state_t st_q;
  cscr_state_t st_d;
  logic [3:0]  cnt_q;
  logic [3:0]  cnt_d;
  cscr_byte_t  sh_d;
  cscr_byte_t  ptr_d;
  cscr_byte_t  tx_q;
  cscr_byte_t  tx_d;
  logic        rw_q;
  logic        rw_d;
  logic        oe_q;
  logic        oe_d;
  logic        sda_o_q;
  logic [6:0]  my_addr;

  assign my_addr = regs_q[`CSCR_IDX_ADDR][`CSCR_B_ADDR_OVR] ?
                   regs_q[`CSCR_IDX_ADDR][6:0] : `CSCR_DEF_DEV;

  always_comb
  begin
    st_d  = st_q;
    cnt_d = cnt_q;
    sh_d  = sh_q;
    ptr_d = ptr_q;
    tx_d  = tx_q;
    rw_d  = rw_q;
    oe_d  = oe_q;
    wr_en = 1'b0;
    if (stop_c)
    begin
      st_d = CSCR_IDLE;
      oe_d = 1'b0;
    end
    else if (start_c)
    begin
      st_d  = CSCR_DEV;
      cnt_d = 4'h0;
      oe_d  = 1'b0;
    end
    else
    begin
      unique case (st_q)
        CSCR_IDLE, CSCR_SKIP:
        begin
        end
        CSCR_DEV, CSCR_REG, CSCR_WDATA:
        begin
          if (scl_rise && cnt_q != 4'h8)
          begin
            sh_d  = {sh_q[6:0], sda_s};
            cnt_d = cnt_q + 4'h1;
          end
          else if (scl_fall && cnt_q == 4'h8)
          begin
            oe_d = 1'b1;
            if (st_q == CSCR_DEV)
            begin
              rw_d = sh_q[0];
              st_d = (sh_q[7:1] == my_addr) ? CSCR_DEV_ACK : CSCR_SKIP;
              oe_d = (sh_q[7:1] == my_addr);
            end
            else if (st_q == CSCR_REG)
            begin
              ptr_d = sh_q;
              st_d  = CSCR_REG_ACK;
            end
            else
            begin
              wr_en = 1'b1;
              st_d  = CSCR_WACK;
            end
          end
        end
        CSCR_DEV_ACK:
        begin
          if (scl_fall && rw_q)
          begin
            tx_d  = rd_data;
            oe_d  = ~rd_data[7];
            cnt_d = 4'h1;
            st_d  = CSCR_RDATA;
          end
          else if (scl_fall)
          begin
            oe_d  = 1'b0;
            cnt_d = 4'h0;
            st_d  = CSCR_REG;
          end
        end
        CSCR_REG_ACK:
        begin
          if (scl_fall)
          begin
            oe_d  = 1'b0;
            cnt_d = 4'h0;
            st_d  = CSCR_WDATA;
          end
        end
        CSCR_WACK:
        begin
          // Writes are single-byte: any further data byte is not acknowledged.
          if (scl_fall)
          begin
            oe_d = 1'b0;
            st_d = CSCR_SKIP;
          end
        end
        CSCR_RDATA:
        begin
          if (scl_fall && cnt_q == 4'h8)
          begin
            oe_d  = 1'b0;
            ptr_d = ptr_q + 8'h01;
            st_d  = CSCR_RACK;
          end
          else if (scl_fall)
          begin
            tx_d  = {tx_q[6:0], 1'b0};
            oe_d  = ~tx_q[6];
            cnt_d = cnt_q + 4'h1;
          end
        end
        CSCR_RACK:
        begin
          if (scl_rise)
            sh_d = {sh_q[6:0], sda_s};
          else if (scl_fall && !sh_q[0])
          begin
            tx_d  = rd_data;
            oe_d  = ~rd_data[7];
            cnt_d = 4'h1;
            st_d  = CSCR_RDATA;
          end
          else if (scl_fall)
            st_d = CSCR_SKIP;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      st_q    <= CSCR_IDLE;
      cnt_q   <= 4'h0;
      sh_q    <= 8'h00;
      ptr_q   <= 8'h00;
      tx_q    <= 8'h00;
      rw_q    <= 1'b0;
      oe_q    <= 1'b0;
      sda_o_q <= 1'b0;
    end
    else
    begin
      st_q    <= st_d;
      cnt_q   <= cnt_d;
      sh_q    <= sh_d;
      ptr_q   <= ptr_d;
      tx_q    <= tx_d;
      rw_q    <= rw_d;
      oe_q    <= oe_d;
      sda_o_q <= 1'b0;
    end
  end

  assign sda_o  = sda_o_q;
  assign sda_oe = oe_q;

  // --------------------------------------------------------------------------
  // Applied setting fields, and the programming control taken straight from its register
  // --------------------------------------------------------------------------
  assign pll_integer_mode = act_q[`CSCR_IDX_PLL3][`CSCR_B_PLL_MODE];
  assign fb_int_high      = act_q[`CSCR_IDX_PLL3][5:4];
  assign cp_offset_en     = act_q[`CSCR_IDX_PLL3][6];
  assign charge_pump      = act_q[`CSCR_IDX_PLL3][3:1];
  assign fb_fraction      = {act_q[`CSCR_IDX_FRAC_H], act_q[`CSCR_IDX_FRAC_M],
                             act_q[`CSCR_IDX_FRAC_L]};
  assign hs_bus_en        = act_q[`CSCR_IDX_BUS][`CSCR_B_BUS_HS];
  assign cmos_out_en      = act_q[`CSCR_IDX_BUS][`CSCR_B_CMOS_EN];
  assign doubler_dis      = act_q[`CSCR_IDX_OSC][`CSCR_B_DBL_DIS];
  assign supply_code      = act_q[`CSCR_IDX_OSC][6:5];
  assign fixed_osc_mode   = act_q[`CSCR_IDX_OSC][`CSCR_B_FIXED];
  assign mod_bandwidth    = act_q[`CSCR_IDX_OSC][1:0];
  assign gain_slope_neg   = act_q[`CSCR_IDX_GAIN][`CSCR_B_SLOPE];
  assign gain_exponent    = act_q[`CSCR_IDX_GAIN][6:4];
  assign gain_scale       = act_q[`CSCR_IDX_GAIN][3:0];
  assign oe_active_high   = act_q[`CSCR_IDX_DRV][`CSCR_B_OE_POL];
  assign logic_type       = act_q[`CSCR_IDX_DRV][6:4];
  assign amplifier_transconductance_code = act_q[`CSCR_IDX_GM];
  assign amp_slice        = act_q[`CSCR_IDX_TRIM][7:4];
  assign xo_bypass        = act_q[`CSCR_IDX_TRIM][`CSCR_B_BYPASS];
  assign load_cap_trim    = act_q[`CSCR_IDX_TRIM][2:0];
  assign fundamental_mode = act_q[`CSCR_IDX_OVT][`CSCR_B_FUND];
  assign filter_res       = act_q[`CSCR_IDX_OVT][6:4];
  assign nv_prog_ctrl     = regs_q[`CSCR_IDX_NVPC][1:0];

endmodule

// ---- sim/cscr_host_bfm.sv ----
// Two-wire bus master model, eight clocks per half of the link period.
// Assumes the bench resolves a pulled-up SDA wire from both pull-downs.
module cscr_host_bfm
(
  // Clock
  input  wire logic ref_clk,
  // Bus wires
  input  wire logic sda,
  output logic      scl,
  output logic      sda_pull
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  // Outside start and stop, SDA moves only mid low phase, so no stray START or STOP is seen.
  task automatic drive(input logic c, input logic p, input int n);
    scl <= c;
    sda_pull <= p;
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic bit_io(input logic b, output logic r);
    drive(1'b0, sda_pull, 4);
    drive(1'b0, !b, 4);
    drive(1'b1, !b, 8);
    r = sda;
  endtask
  task automatic start();
    drive(1'b0, sda_pull, 4);
    drive(1'b0, 1'b0, 4);
    drive(1'b1, 1'b0, 8);
    drive(1'b1, 1'b1, 8);
  endtask
  task automatic stop();
    drive(1'b0, sda_pull, 4);
    drive(1'b0, 1'b1, 4);
    drive(1'b1, 1'b1, 8);
    drive(1'b1, 1'b0, 8);
  endtask
  task automatic xfer(input logic [7:0] d, input logic ak, output logic [7:0] q, output logic a);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(d[i], r);
      q[i] = r;
    end
    bit_io(ak, a);
  endtask
endmodule

// ---- sim/cscr_top_sva.sv ----
// Port checker for the configuration bank, bound to cscr_top.
// Assumes one clock domain and the pin timing of the two-wire slave.
module cscr_top_sva
(
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        rst_b,
  // Watched ports
  input wire logic        scl_i,
  input wire logic        sda_o,
  input wire logic        sda_oe,
  input wire logic        cal_start,
  input wire logic [1:0]  nv_prog_ctrl,
  input wire logic [2:0]  charge_pump,
  input wire logic [23:0] fb_fraction
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  a_reset_quiet: assert property (disable iff (1'b0) !rst_b [*2] |-> !sda_oe && !cal_start)
    else $error("Bus or strobe active in reset");
  a_reset_defaults: assert property ($rose(rst_b) |-> fb_fraction == 24'hc0_0000 && charge_pump == 3'b101)
    else $error("Profile defaults wrong");
  a_open_drain: assert property (sda_o == 1'b0)
    else $error("Data pin driven high");
  a_ack_scl_low: assert property ($changed(sda_oe) |-> !scl_i && !$past(scl_i, 2))
    else $error("Data enable moved near clock high");
  a_cal_single_pulse: assert property (cal_start |=> (!cal_start) [*8])
    else $error("Calibration strobe repeated");
  a_cal_in_low: assert property (cal_start |-> !scl_i && !$past(scl_i, 3))
    else $error("Calibration strobe out of place");
  a_fields_settle: assert property ($changed(fb_fraction) |=> $stable(fb_fraction) [*8])
    else $error("Fraction moved outside a push");
  a_nvprog_low: assert property ($changed(nv_prog_ctrl) |-> !scl_i)
    else $error("Programming field moved near clock high");
  a_cp_quiet: assert property (scl_i && $past(scl_i) |-> $stable(charge_pump))
    else $error("Charge pump moved in clock high");
endmodule

// ---- sim/test_cscr_top.sv ----
// Self-checking bench for the configuration bank and its two-wire slave.
// Assumes cscr_host_bfm as bus master; the checker is bound at the foot.
`include "cscr_map.svh"
module test_cscr_top;
  timeunit 1ns;
  timeprecision 1ps;
  import cscr_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic scl_i, sda_pull, sda_o, sda_oe, pll_integer_mode, cp_offset_en, hs_bus_en, cmos_out_en;
  logic doubler_dis, fixed_osc_mode, gain_slope_neg, oe_active_high, xo_bypass, cal_start;
  logic fundamental_mode;
  logic [1:0] fb_int_high, supply_code, mod_bandwidth, nv_prog_ctrl;
  logic [2:0] charge_pump, gain_exponent, logic_type, load_cap_trim, filter_res;
  logic [3:0] gain_scale, amp_slice;
  logic [23:0] fb_fraction;
  cscr_byte_t amplifier_transconductance_code;
  logic [`CSCR_NREG*8-1:0] nv_image = '0;
  wire sda_i = !(sda_oe || sda_pull);
  logic [7:0] ap [12];
  logic [7:0] exp_q[$], got_q[$];
  string nm_q[$];
  int err_count = 0;
  int n_checks = 0;
  int n_cal = 0;
  localparam logic [7:0] offs [12] = '{8'h42, 8'h43, 8'h44, 8'h45, 8'h50, 8'h51, 8'h52, 8'h53,
    8'h54, 8'h55, 8'h56, 8'h57};
  localparam logic [7:0] rstv [12] = '{8'h0a, 8'h00, 8'h00, 8'hc0, 8'h15, 8'hc0, 8'h2a, 8'h82,
    8'h00, 8'h94, 8'h82, 8'h58};
  // Bits of each byte that reach an applied output.
  localparam logic [7:0] msk [12] = '{8'h7f, 8'hff, 8'hff, 8'hff, 8'h18, 8'he7, 8'hff, 8'hf0,
    8'h00, 8'hff, 8'hff, 8'hf0};
  localparam logic [7:0] cal_seq [5] = '{8'h01, 8'h01, 8'h00, 8'h01, 8'h00};
  assign ap = '{{1'b0, cp_offset_en, fb_int_high, charge_pump, pll_integer_mode},
    fb_fraction[7:0], fb_fraction[15:8], fb_fraction[23:16], {3'h0, hs_bus_en, cmos_out_en, 3'h0},
    {doubler_dis, supply_code, 2'h0, fixed_osc_mode, mod_bandwidth},
    {gain_slope_neg, gain_exponent, gain_scale}, {oe_active_high, logic_type, 4'h0}, 8'h00,
    amplifier_transconductance_code, {amp_slice, xo_bypass, load_cap_trim},
    {fundamental_mode, filter_res, 4'h0}};
  cscr_top cscr_top_i (.*);
  cscr_host_bfm cscr_host_bfm_i (.ref_clk(ref_clk), .sda(sda_i), .scl(scl_i), .sda_pull(sda_pull));
  initial forever #2 ref_clk = !ref_clk;
  task automatic note(input string nm, input logic [7:0] e);
    nm_q.push_back(nm);
    exp_q.push_back(e);
  endtask
  task automatic seen(input logic [7:0] v);
    got_q.push_back(v);
  endtask
  task automatic check(input string nm, input logic [7:0] got, input logic [7:0] e);
    n_checks++;
    if (got !== e)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, got);
    end
  endtask
  task automatic wr(input logic [6:0] dev, input logic [7:0] off, dat, input logic [2:0] ek);
    logic [7:0] q;
    logic [2:0] a;
    cscr_host_bfm_i.start();
    cscr_host_bfm_i.xfer({dev, 1'b0}, 1'b1, q, a[2]);
    cscr_host_bfm_i.xfer(off, 1'b1, q, a[1]);
    cscr_host_bfm_i.xfer(dat, 1'b1, q, a[0]);
    cscr_host_bfm_i.stop();
    note("ack", {5'h0, ek});
    seen({5'h0, a});
  endtask
  task automatic rd(input logic [6:0] dev, input logic [7:0] off);
    logic [7:0] q;
    logic a;
    cscr_host_bfm_i.start();
    cscr_host_bfm_i.xfer({dev, 1'b0}, 1'b1, q, a);
    cscr_host_bfm_i.xfer(off, 1'b1, q, a);
    cscr_host_bfm_i.start();
    cscr_host_bfm_i.xfer({dev, 1'b1}, 1'b1, q, a);
    cscr_host_bfm_i.xfer(8'hff, 1'b1, q, a);
    cscr_host_bfm_i.stop();
    seen(q);
  endtask
  task automatic print_verdict();
    err_count += exp_q.size() + got_q.size();
    $display("Checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(posedge ref_clk)
  begin
    if (cal_start === 1'b1)
      n_cal++;
    while (got_q.size() > 0 && exp_q.size() > 0)
      check(nm_q.pop_front(), got_q.pop_front(), exp_q.pop_front());
  end
  initial
  begin
    logic [7:0] d [12];
    logic [127:0] img;
    d[0] = 8'($urandom(38));
    repeat (12) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (8) @(posedge ref_clk);
    for (int i = 0; i < 12; i++)
    begin
      note("reset reg", rstv[i]);
      rd(7'h50, offs[i]);
      note("reset out", rstv[i] & msk[i]);
      seen(ap[i]);
    end
    wr(7'h50, 8'h70, 8'h5a, 3'h0);
    note("unmapped", 8'h00);
    rd(7'h50, 8'h70);
    for (int i = 0; i < 12; i++)
    begin
      // Reserved bits keep the defaults read back above; only live fields are randomised.
      d[i] = (8'($urandom) & msk[i]) | (rstv[i] & ~msk[i]);
      wr(7'h50, offs[i], d[i], 3'h0);
      note("held out", rstv[i] & msk[i]);
      seen(ap[i]);
      note("readback", d[i]);
      rd(7'h50, offs[i]);
    end
    wr(7'h50, 8'h60, 8'h20, 3'h0);
    wr(7'h50, 8'h60, 8'h00, 3'h0);
    for (int i = 0; i < 12; i++)
    begin
      note("pushed", d[i] & msk[i]);
      seen(ap[i]);
    end
    for (int i = 1; i >= 0; i--)
    begin
      d[3] = 8'($urandom);
      wr(7'h50, 8'h45, d[3], 3'h0);
      wr(7'h50, 8'h62, 8'(1 << i), 3'h0);
      note("push two", d[3]);
      seen(ap[3]);
      wr(7'h50, 8'h62, 8'h00, 3'h0);
    end
    foreach (cal_seq[k])
      wr(7'h50, 8'h60, cal_seq[k], 3'h0);
    note("cal count", 8'd2);
    seen(8'(n_cal));
    wr(7'h50, 8'h61, 8'h03, 3'h0);
    note("prog", 8'h03);
    seen({6'h0, nv_prog_ctrl});
    img = {$urandom, $urandom, $urandom, $urandom};
    img[71:64] = 8'h00;
    nv_image <= img[119:0];
    wr(7'h50, 8'h60, 8'h80, 3'h0);
    note("copy", 8'h80);
    rd(7'h50, 8'h60);
    note("copy", img[111:104]);
    rd(7'h50, 8'h61);
    wr(7'h50, 8'h60, 8'h00, 3'h0);
    wr(7'h50, 8'h54, 8'hab, 3'h0);
    wr(7'h50, 8'h43, 8'h11, 3'h7);
    note("new addr", 8'hab);
    rd(7'h2b, 8'h54);
    wr(7'h2b, 8'h54, 8'h00, 3'h0);
    note("ignored", img[15:8]);
    rd(7'h50, 8'h43);
    repeat (4) @(posedge ref_clk);
    print_verdict();
  end
endmodule
bind cscr_top cscr_top_sva cscr_top_sva_i (.*);
